// ---- rtl/rrag_top.sv ----
// Rotated refresh address generator: walks the display buffer in rotated order
// ------------------------------------------------------------
// Summary of operation
// [R1] The refresh shows the image turned counter-clockwise by 90, 180 or 270 degrees, done by hardware.
// [R2] CPU buffer accesses pass untranslated; only refresh fetch order changes.
// [R3] Pixel doubling is forced off whenever 90 or 270 degree rotation is selected.
// [R4] The system must clock memory at least 1.25 times the pixel clock for 90 and 270 degrees.
// [R5] Mode register bits 17:16 select 01 = 90, 10 = 180 and 11 = 270 degrees.
// [R6] At 90 degrees the scan starts at corner B and runs B, D, A, C.
// [R7] At 180 degrees the scan starts at corner D and runs D, C, B, A.
// [R8] At 270 degrees the scan starts at corner C and runs C, A, D, B.
// [R9] For 90 degrees software loads start = ((addr + height*bpp/8)/4) - 1.
// [R10] For 180 degrees software loads start = ((addr + (pitch*(height-1)+width)*bpp/8)/4) - 1.
// [R11] For 270 degrees software loads start = addr + ((width-1)*pitch*bpp/8)/4.
// [R12] The 10-bit pitch holds display width divided by (32/bpp), in words.
// [R13] An overlay window placed anywhere in the virtual display is fetched from its own registers.
// [R14] The overlay uses the main window's colour depth and rotation, with no own setting.
// [R15] Rotation 00 scans unrotated, left to right and top to bottom from the start address.
// ------------------------------------------------------------
module rrag_top
	import rrag_pkg::*;
(
	input  wire logic        i_core_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic        i_frame_start,
	input  wire logic        i_cpu_valid,
	input  wire logic [16:0] i_cpu_addr,
	output logic      [16:0] o_cpu_mem_addr,
	output logic             o_cpu_mem_valid,
	output logic             o_fetch_valid,
	output logic      [16:0] o_fetch_addr,
	output logic             o_fetch_overlay,
	input  wire logic        i_fetch_ready,
	output logic      [1:0]  o_rotation,
	output logic      [2:0]  o_color_depth,
	output logic             o_pixel_double,
	output logic             o_busy
);
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [31:0] mode;
	logic [31:0] start;
	logic [31:0] pitch;
	logic [31:0] ovl_x;
	logic [31:0] ovl_y;
	logic [31:0] ovl_addr;
	logic [31:0] ovl_ctrl;
	logic [31:0] panel;
	logic [31:0] status;

	rrag_apb_regs u_regs
	(
		.i_core_clk (i_core_clk),
		.i_arst_n   (i_arst_n),
		.i_psel     (i_psel),
		.i_penable  (i_penable),
		.i_pwrite   (i_pwrite),
		.i_paddr    (i_paddr),
		.i_pwdata   (i_pwdata),
		.i_status   (status),
		.o_prdata   (o_prdata),
		.o_pready   (o_pready),
		.o_pslverr  (o_pslverr),
		.o_mode     (mode),
		.o_start    (start),
		.o_pitch    (pitch),
		.o_ovl_x    (ovl_x),
		.o_ovl_y    (ovl_y),
		.o_ovl_addr (ovl_addr),
		.o_ovl_ctrl (ovl_ctrl),
		.o_panel    (panel)
	);

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	rrag_rot_type rot;
	logic         portrait;
	logic [9:0]   width_m1;
	logic [9:0]   height_m1;
	logic [9:0]   words_m1;
	logic [9:0]   lines_m1;
	logic [9:0]   pitch_w;
	logic [16:0]  pitch_x;
	logic [2:0]   bpp_code;
	logic [16:0]  step_pix;
	logic [16:0]  step_line;
	logic [9:0]   ox0;
	logic [9:0]   ox1;
	logic [9:0]   oy0;
	logic [9:0]   oy1;

	assign rot       = rrag_rot_type'(mode[RRAG_ROT_MSB:RRAG_ROT_LSB]); // [R5]
	assign portrait  = (rot == RRAG_ROT_90) || (rot == RRAG_ROT_270);
	assign bpp_code  = mode[RRAG_BPP_MSB:RRAG_BPP_LSB];
	assign width_m1  = panel[RRAG_DIM_W-1:0];
	assign height_m1 = panel[RRAG_HI_LSB+RRAG_DIM_W-1:RRAG_HI_LSB];
	assign pitch_w   = pitch[RRAG_PITCH_W-1:0]; // [R12]
	assign pitch_x   = {7'h00, pitch_w};
	// Panel width is in pixels; landscape rows are word runs of width*bpp/32
	// Widened before the shift so that a full-width panel at deep colour cannot wrap
	assign words_m1  = 10'(((18'(width_m1) + 18'h00001) << bpp_code) >> 5) - 10'h001;
	// Portrait scans fetch one word per panel row of the rotated buffer column
	assign lines_m1  = portrait ? words_m1 : height_m1;
	// Overlay bounds share the main window's depth and rotation: no own fields [R14]
	assign ox0 = ovl_x[RRAG_DIM_W-1:0];
	assign ox1 = ovl_x[RRAG_HI_LSB+RRAG_DIM_W-1:RRAG_HI_LSB];
	assign oy0 = ovl_y[RRAG_DIM_W-1:0];
	assign oy1 = ovl_y[RRAG_HI_LSB+RRAG_DIM_W-1:RRAG_HI_LSB];

	// Per-rotation address steps: along the refresh row, and between rows [R1]
	always_comb
	begin
		step_pix  = 17'h00001;
		step_line = pitch_x;
		case (rot)
			RRAG_ROT_0:
			begin
				step_pix  = 17'h00001; // [R15]
				step_line = pitch_x;
			end
			RRAG_ROT_90:
			begin
				step_pix  = pitch_x; // [R6]
				step_line = 17'h1ffff;
			end
			RRAG_ROT_180:
			begin
				step_pix  = 17'h1ffff; // [R7]
				step_line = 17'(-pitch_x);
			end
			RRAG_ROT_270:
			begin
				step_pix  = 17'(-pitch_x); // [R8]
				step_line = 17'h00001;
			end
			default:
			begin
				step_pix  = 17'h00001;
				step_line = pitch_x;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Scan state
	// ------------------------------------------------------------
	typedef struct packed
	{
		rrag_state_type st;
		logic [16:0]    row_base;
		logic [16:0]    addr;
		logic [16:0]    ovl_row;
		logic [16:0]    ovl_ptr;
		logic [9:0]     col;
		logic [9:0]     line;
		logic [15:0]    frames;
	} rrag_scan_type;

	rrag_scan_type s_q;
	rrag_scan_type s_d;
	logic          in_ovl;
	logic          ovl_row_hit;
	logic          buf_ready;
	logic          gen_valid;
	logic [17:0]   gen_data;
	logic [17:0]   out_data;

	assign ovl_row_hit = ovl_ctrl[RRAG_OVL_EN] && (s_q.line >= oy0) && (s_q.line <= oy1);
	assign in_ovl      = ovl_row_hit && (s_q.col >= ox0) && (s_q.col <= ox1); // [R13]
	assign gen_valid   = (s_q.st == RRAG_ST_RUN);
	// Overlay words come from their own base but walk with the main steps [R14]
	assign gen_data    = in_ovl ? {1'b1, s_q.ovl_ptr} : {1'b0, s_q.addr}; // [R2]

	always_comb
	begin
		s_d = s_q;
		case (s_q.st)
			RRAG_ST_IDLE:
			begin
				if (i_frame_start)
				begin
					s_d.st       = RRAG_ST_RUN;
					s_d.row_base = start[RRAG_ADDR_W-1:0]; // [R1]
					s_d.addr     = start[RRAG_ADDR_W-1:0];
					s_d.ovl_row  = ovl_addr[RRAG_ADDR_W-1:0];
					s_d.ovl_ptr  = ovl_addr[RRAG_ADDR_W-1:0];
					s_d.col      = 10'h000;
					s_d.line     = 10'h000;
				end
			end
			RRAG_ST_RUN:
			begin
				// Back-pressure from the buffer holds the scan in place
				if (buf_ready)
				begin
					s_d.addr = s_q.addr + step_pix;
					if (in_ovl)
						s_d.ovl_ptr = s_q.ovl_ptr + step_pix;
					if (s_q.col == (portrait ? height_m1 : words_m1))
					begin
						s_d.col      = 10'h000;
						s_d.line     = s_q.line + 10'h001;
						s_d.row_base = s_q.row_base + step_line;
						s_d.addr     = s_q.row_base + step_line;
						if (ovl_row_hit)
						begin
							s_d.ovl_row = s_q.ovl_row + step_line;
							s_d.ovl_ptr = s_q.ovl_row + step_line;
						end
						else
							s_d.ovl_ptr = s_q.ovl_row;
						if (s_q.line == lines_m1)
							s_d.st = RRAG_ST_WRAP;
					end
					else
						s_d.col = s_q.col + 10'h001;
				end
			end
			RRAG_ST_WRAP:
			begin
				s_d.frames = s_q.frames + 16'h0001;
				s_d.st     = RRAG_ST_IDLE;
			end
			default: s_d.st = RRAG_ST_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// ------------------------------------------------------------
	// Output buffer
	// ------------------------------------------------------------
	rrag_skid_buf #(.WIDTH(18)) u_buf
	(
		.i_core_clk (i_core_clk),
		.i_arst_n   (i_arst_n),
		.i_valid    (gen_valid),
		.i_data     (gen_data),
		.o_ready    (buf_ready),
		.o_valid    (o_fetch_valid),
		.o_data     (out_data),
		.i_ready    (i_fetch_ready)
	);

	assign o_fetch_addr    = out_data[16:0];
	assign o_fetch_overlay = out_data[17];

	// CPU path is a straight pass: no address translation at all [R2]
	assign o_cpu_mem_addr  = i_cpu_addr;
	assign o_cpu_mem_valid = i_cpu_valid;

	assign o_rotation     = rot;
	assign o_color_depth  = bpp_code; // [R14]
	assign o_pixel_double = mode[RRAG_DBL_BIT] && !portrait; // [R3]
	assign o_busy         = (s_q.st != RRAG_ST_IDLE);
	assign status         = {s_q.frames, 6'h00, s_q.line};
endmodule // rrag_top

// ---- rtl/rrag_pkg.sv ----
// Package: register map, field layout and encodings of the rotated refresh address generator
package rrag_pkg;
	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] RRAG_OFS_MODE     = 8'h10;
	localparam logic [7:0] RRAG_OFS_START    = 8'h40;
	localparam logic [7:0] RRAG_OFS_PITCH    = 8'h44;
	localparam logic [7:0] RRAG_OFS_OVL_X    = 8'h50;
	localparam logic [7:0] RRAG_OFS_OVL_Y    = 8'h54;
	localparam logic [7:0] RRAG_OFS_OVL_ADDR = 8'h58;
	localparam logic [7:0] RRAG_OFS_OVL_CTRL = 8'h5c;
	localparam logic [7:0] RRAG_OFS_PANEL    = 8'h60;
	localparam logic [7:0] RRAG_OFS_STATUS   = 8'h64;
	// ------------------------------------------------------------
	// Field layout
	// ------------------------------------------------------------
	localparam int RRAG_ROT_LSB   = 16;
	localparam int RRAG_ROT_MSB   = 17;
	localparam int RRAG_DBL_BIT   = 8;
	localparam int RRAG_BPP_LSB   = 0;
	localparam int RRAG_BPP_MSB   = 2;
	localparam int RRAG_ADDR_W    = 17;
	localparam int RRAG_PITCH_W   = 10;
	localparam int RRAG_DIM_W     = 10;
	localparam int RRAG_OVL_EN    = 0;
	localparam int RRAG_HI_LSB    = 16;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [31:0] RRAG_RST_MODE  = 32'h0000_0003;
	localparam logic [31:0] RRAG_RST_ZERO  = 32'h0000_0000;
	localparam logic [31:0] RRAG_RST_PANEL = 32'h00ef_013f;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		RRAG_ROT_0   = 2'h0,
		RRAG_ROT_90  = 2'h1,
		RRAG_ROT_180 = 2'h2,
		RRAG_ROT_270 = 2'h3
	} rrag_rot_type;
	typedef enum logic [1:0]
	{
		RRAG_ST_IDLE  = 2'h0,
		RRAG_ST_RUN   = 2'h1,
		RRAG_ST_WRAP  = 2'h3
	} rrag_state_type;
endpackage

// ---- rtl/rrag_apb_regs.sv ----
// APB register slave of the rotated refresh address generator
module rrag_apb_regs
	import rrag_pkg::*;
(
	input  wire logic        i_core_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [31:0] i_status,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic      [31:0] o_mode,
	output logic      [31:0] o_start,
	output logic      [31:0] o_pitch,
	output logic      [31:0] o_ovl_x,
	output logic      [31:0] o_ovl_y,
	output logic      [31:0] o_ovl_addr,
	output logic      [31:0] o_ovl_ctrl,
	output logic      [31:0] o_panel
);
	typedef struct packed
	{
		logic [31:0] mode;
		logic [31:0] start;
		logic [31:0] pitch;
		logic [31:0] ovl_x;
		logic [31:0] ovl_y;
		logic [31:0] ovl_addr;
		logic [31:0] ovl_ctrl;
		logic [31:0] panel;
		logic [31:0] rdata;
		logic        err;
	} rrag_regs_type;

	rrag_regs_type r_q;
	rrag_regs_type r_d;
	logic          hit;
	logic [31:0]   rd;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	always_comb
	begin
		hit = 1'b1;
		rd  = 32'h0000_0000;
		case (i_paddr)
			RRAG_OFS_MODE:     rd = r_q.mode;
			RRAG_OFS_START:    rd = r_q.start;
			RRAG_OFS_PITCH:    rd = r_q.pitch;
			RRAG_OFS_OVL_X:    rd = r_q.ovl_x;
			RRAG_OFS_OVL_Y:    rd = r_q.ovl_y;
			RRAG_OFS_OVL_ADDR: rd = r_q.ovl_addr;
			RRAG_OFS_OVL_CTRL: rd = r_q.ovl_ctrl;
			RRAG_OFS_PANEL:    rd = r_q.panel;
			RRAG_OFS_STATUS:   rd = i_status;
			default:           hit = 1'b0;
		endcase
	end

	always_comb
	begin
		r_d = r_q;
		if (i_psel && !i_penable)
		begin
			// Answer is prepared in setup so the access phase completes at once
			r_d.rdata = hit ? rd : 32'h0000_0000;
			r_d.err   = !hit;
		end
		if (i_psel && i_penable && i_pwrite && hit)
		begin
			case (i_paddr)
				RRAG_OFS_MODE:     r_d.mode     = i_pwdata;
				RRAG_OFS_START:    r_d.start    = {15'h0000, i_pwdata[RRAG_ADDR_W-1:0]};
				RRAG_OFS_PITCH:    r_d.pitch    = {22'h000000, i_pwdata[RRAG_PITCH_W-1:0]};
				RRAG_OFS_OVL_X:    r_d.ovl_x    = i_pwdata;
				RRAG_OFS_OVL_Y:    r_d.ovl_y    = i_pwdata;
				RRAG_OFS_OVL_ADDR: r_d.ovl_addr = {15'h0000, i_pwdata[RRAG_ADDR_W-1:0]};
				RRAG_OFS_OVL_CTRL: r_d.ovl_ctrl = {31'h00000000, i_pwdata[RRAG_OVL_EN]};
				RRAG_OFS_PANEL:    r_d.panel    = i_pwdata;
				default:           r_d.err      = r_q.err;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			r_q.mode     <= RRAG_RST_MODE;
			r_q.start    <= RRAG_RST_ZERO;
			r_q.pitch    <= RRAG_RST_ZERO;
			r_q.ovl_x    <= RRAG_RST_ZERO;
			r_q.ovl_y    <= RRAG_RST_ZERO;
			r_q.ovl_addr <= RRAG_RST_ZERO;
			r_q.ovl_ctrl <= RRAG_RST_ZERO;
			r_q.panel    <= RRAG_RST_PANEL;
			r_q.rdata    <= RRAG_RST_ZERO;
			r_q.err      <= 1'b0;
		end
		else
			r_q <= r_d;
	end

	assign o_pready   = 1'b1;
	assign o_prdata   = r_q.rdata;
	assign o_pslverr  = r_q.err && i_psel && i_penable;
	assign o_mode     = r_q.mode;
	assign o_start    = r_q.start;
	assign o_pitch    = r_q.pitch;
	assign o_ovl_x    = r_q.ovl_x;
	assign o_ovl_y    = r_q.ovl_y;
	assign o_ovl_addr = r_q.ovl_addr;
	assign o_ovl_ctrl = r_q.ovl_ctrl;
	assign o_panel    = r_q.panel;
endmodule // rrag_apb_regs

// ---- rtl/rrag_skid_buf.sv ----
// Two-entry valid/ready buffer for the fetch address stream
module rrag_skid_buf
	import rrag_pkg::*;
#(
	parameter int WIDTH = 18
)
(
	input  wire logic             i_core_clk,
	input  wire logic             i_arst_n,
	input  wire logic             i_valid,
	input  wire logic [WIDTH-1:0] i_data,
	output logic                  o_ready,
	output logic                  o_valid,
	output logic      [WIDTH-1:0] o_data,
	input  wire logic             i_ready
);
	typedef struct packed
	{
		logic [1:0][WIDTH-1:0] mem;
		logic [1:0]            cnt;
	} rrag_buf_type;

	rrag_buf_type s_q;
	rrag_buf_type s_d;
	logic         push;
	logic         pop;

	assign o_ready = (s_q.cnt != 2'h2);
	assign o_valid = (s_q.cnt != 2'h0);
	assign o_data  = s_q.mem[0];
	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;

	always_comb
	begin
		s_d = s_q;
		if (pop)
			s_d.mem[0] = s_q.mem[1];
		if (push)
			s_d.mem[(s_q.cnt == 2'h0 || (pop && s_q.cnt == 2'h1)) ? 0 : 1] = i_data;
		s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end
endmodule // rrag_skid_buf

// ---- dv/rrag_fetch_sink.sv ----
// Partner model: pixel pipeline that takes refresh fetch words, promptly or with stalls
module rrag_fetch_sink
(
	input  wire logic i_core_clk,
	input  wire logic i_arst_n,
	input  wire logic i_slow,
	output logic      o_fetch_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] cnt_q;
	// Slow mode takes one word in three cycles, so the buffer must hold words meanwhile
	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			cnt_q         <= 2'h0;
			o_fetch_ready <= 1'b0;
		end
		else
		begin
			cnt_q         <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
			o_fetch_ready <= !i_slow || (cnt_q == 2'h2);
		end
	end
endmodule // rrag_fetch_sink

// ---- dv/rrag_top_chk.sv ----
// Checker: port-level assertions of the rotated refresh address generator
module rrag_top_chk
	import rrag_pkg::*;
(
	input wire logic        i_core_clk,
	input wire logic        i_arst_n,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [7:0]  i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic        i_frame_start,
	input wire logic        i_cpu_valid,
	input wire logic [16:0] i_cpu_addr,
	input wire logic [16:0] o_cpu_mem_addr,
	input wire logic        o_cpu_mem_valid,
	input wire logic        o_fetch_valid,
	input wire logic [16:0] o_fetch_addr,
	input wire logic        i_fetch_ready,
	input wire logic [1:0]  o_rotation,
	input wire logic [2:0]  o_color_depth,
	input wire logic        o_pixel_double,
	input wire logic        o_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_arst_n);
	logic mode_wr;
	logic mapped;
	assign mode_wr = i_psel && i_penable && i_pwrite && (i_paddr == RRAG_OFS_MODE);
	assign mapped = i_paddr inside {8'h10, 8'h40, 8'h44, 8'h50, 8'h54, 8'h58, 8'h5c, 8'h60, 8'h64};
	apb_ready_a: assert property (i_psel && i_penable |-> o_pready)
		else $error("access phase without ready");
	unmapped_err_a: assert property (i_psel && i_penable |-> o_pslverr == !mapped)
		else $error("error response does not match the address map");
	rot_load_a: assert property (mode_wr |=> o_rotation == $past(i_pwdata[17:16]))
		else $error("rotation output differs from the written select");
	rot_hold_a: assert property (!mode_wr |=> $stable(o_rotation))
		else $error("rotation changed without a mode write");
	depth_load_a: assert property (mode_wr |=> o_color_depth == $past(i_pwdata[2:0]))
		else $error("colour depth differs from the written value");
	double_gate_a: assert property (mode_wr |=>
		o_pixel_double == ($past(i_pwdata[8]) && !$past(i_pwdata[16])))
		else $error("pixel doubling not gated by rotation");
	cpu_pass_a: assert property (i_cpu_valid |->
		o_cpu_mem_valid && o_cpu_mem_addr == i_cpu_addr)
		else $error("cpu buffer address translated");
	stall_hold_a: assert property (o_fetch_valid && !i_fetch_ready |=>
		o_fetch_valid && $stable(o_fetch_addr))
		else $error("fetch word lost or changed during stall");
	first_word_a: assert property (i_frame_start && !o_busy && !o_fetch_valid |->
		##2 o_fetch_valid)
		else $error("first fetch word late");
	cover property (mode_wr && i_pwdata[17:16] == 2'h3);
	cover property (o_fetch_valid && !i_fetch_ready);
	cover property (i_psel && i_penable && o_pslverr);
endmodule // rrag_top_chk

bind rrag_top rrag_top_chk chk_u (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.i_frame_start(i_frame_start), .i_cpu_valid(i_cpu_valid), .i_cpu_addr(i_cpu_addr),
	.o_cpu_mem_addr(o_cpu_mem_addr), .o_cpu_mem_valid(o_cpu_mem_valid),
	.o_fetch_valid(o_fetch_valid), .o_fetch_addr(o_fetch_addr),
	.i_fetch_ready(i_fetch_ready), .o_rotation(o_rotation),
	.o_color_depth(o_color_depth), .o_pixel_double(o_pixel_double), .o_busy(o_busy));

// ---- dv/rrag_top_bench.sv ----
// Testbench of the rotated refresh address generator
module rrag_top_bench
	import rrag_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------
	// Start addresses and pitches as software would load them
	// ------------------------------------------------------------
	localparam int ST90  = ((0 + 320 * 8 / 8) / 4) - 1;
	localparam int ST180 = ((0 + (480 * (320 - 1) + 480) * 8 / 8) / 4) - 1;
	localparam int ST270 = 0 + ((480 - 1) * 320 * 8 / 8) / 4;
	localparam int PT_P  = 320 / (32 / 8);
	localparam int PT_L  = 480 / (32 / 8);
	logic [16:0] st [4] = '{17'h00100, 17'(ST90), 17'(ST180), 17'(ST270)};
	logic [16:0] pt [4] = '{17'(PT_P), 17'(PT_P), 17'(PT_L), 17'(PT_P)};
	logic        core_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        frame_start = 1'b0;
	logic        cpu_valid = 1'b0;
	logic [16:0] cpu_addr = 17'h0;
	logic        slow = 1'b0;
	logic        fetch_ready;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [16:0] cpu_mem_addr;
	logic        cpu_mem_valid;
	logic        fetch_valid;
	logic [16:0] fetch_addr;
	logic [1:0]  rotation;
	logic [2:0]  color_depth;
	logic        pixel_double;
	logic        busy;
	logic [31:0] rdat;
	logic        rerr;
	logic        fetch_overlay;
	logic [17:0] got [$];
	logic [16:0] step;
	logic [16:0] lstep;
	int          n_mismatch = 0;
	int          n_checks = 0;
	int          k;
	always #50 core_clk = ~core_clk;
	rrag_top dut_u (.i_core_clk(core_clk), .i_arst_n(arst_n), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_frame_start(frame_start), .i_cpu_valid(cpu_valid), .i_cpu_addr(cpu_addr),
		.o_cpu_mem_addr(cpu_mem_addr), .o_cpu_mem_valid(cpu_mem_valid),
		.o_fetch_valid(fetch_valid), .o_fetch_addr(fetch_addr),
		.o_fetch_overlay(fetch_overlay),
		.i_fetch_ready(fetch_ready), .o_rotation(rotation), .o_color_depth(color_depth),
		.o_pixel_double(pixel_double), .o_busy(busy));
	rrag_fetch_sink sink_u (.i_core_clk(core_clk), .i_arst_n(arst_n), .i_slow(slow),
		.o_fetch_ready(fetch_ready));
	always @(posedge core_clk)
		if (fetch_valid === 1'b1 && fetch_ready === 1'b1)
			got.push_back({fetch_overlay, fetch_addr});
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic final_report();
		if (n_mismatch == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			n_mismatch++;
			final_report();
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (10) @(posedge core_clk);
		arst_n <= 1'b1;
		apb(RRAG_OFS_MODE, 1'b0, 32'h0);
		chk(rdat, RRAG_RST_MODE);
		apb(RRAG_OFS_PANEL, 1'b0, 32'h0);
		chk(rdat, RRAG_RST_PANEL);
		apb(8'h20, 1'b1, 32'hffff_ffff);
		apb(8'h20, 1'b0, 32'h0);
		chk(rerr, 1'b1);
		chk(rdat, 32'h0);
		// Panel of 8 by 2 pixels at 8 bpp: two fetches a row and two rows a frame
		apb(RRAG_OFS_PANEL, 1'b1, 32'h0001_0007);
		// Overlay covers only the second fetch of the second row
		apb(RRAG_OFS_OVL_X, 1'b1, 32'h0001_0001);
		apb(RRAG_OFS_OVL_Y, 1'b1, 32'h0001_0001);
		apb(RRAG_OFS_OVL_ADDR, 1'b1, 32'h0000_0200);
		apb(RRAG_OFS_OVL_CTRL, 1'b1, 32'h0000_0001);
		@(posedge core_clk);
		cpu_valid <= 1'b1;
		cpu_addr <= 17'h1abcd;
		@(negedge core_clk);
		chk({cpu_mem_valid, cpu_mem_addr}, {1'b1, 17'h1abcd});
		for (int r = 0; r < 4; r++)
		begin
			step = (r == 0) ? 17'h1 : (r == 1) ? pt[r] : (r == 2) ? '1 : -pt[r];
			lstep = (r == 0) ? pt[r] : (r == 1) ? '1 : (r == 2) ? -pt[r] : 17'h1;
			apb(RRAG_OFS_START, 1'b1, {15'h0, st[r]});
			apb(RRAG_OFS_PITCH, 1'b1, {15'h0, pt[r]});
			apb(RRAG_OFS_MODE, 1'b1, {14'h0, 2'(r), 16'h0103});
			apb(RRAG_OFS_START, 1'b0, 32'h0);
			chk(rdat, {15'h0, st[r]});
			@(negedge core_clk);
			chk({rotation, color_depth}, {2'(r), 3'h3});
			chk(pixel_double, (r % 2) == 0);
			got.delete();
			@(posedge core_clk);
			slow <= (r % 2) == 1;
			frame_start <= 1'b1;
			@(posedge core_clk);
			frame_start <= 1'b0;
			for (k = 0; got.size() < 4 && k < 200; k++)
				@(posedge core_clk);
			if (got.size() < 4)
			begin
				n_mismatch++;
				final_report();
			end
			chk(got[0], {1'b0, st[r]});
			chk(got[1], {1'b0, st[r] + step});
			chk(got[2], {1'b0, st[r] + lstep});
			chk(got[3], {1'b1, 17'h00200});
			for (k = 0; (busy !== 1'b0 || fetch_valid !== 1'b0) && k < 2000; k++)
				@(posedge core_clk);
			chk({busy, fetch_valid}, 2'h0);
			chk(got.size(), 32'h4);
		end
		final_report();
	end
endmodule // rrag_top_bench
